// File: bench/adc_sequence_control_bench.sv
`timescale 1ns/1ps
module adc_sequence_control_bench
  import conv_seq_pkg::*;
();
  logic        CLK, RST_B, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic        EXT_INT_EDGE, TIMER_MATCH, PWM_INTERVAL, TOUCH_TRIGGER, SAMPLE_HOLD, CONVERT_START, SCAN_STEP;
  logic        NEG_TO_GROUND, RESULT_WE, CONV_IRQ;
  logic [1:0]  BRESP, RRESP;
  logic [2:0]  POS_INPUT_1, POS_INPUT_2, POS_INPUT_3, POS_OPEN;
  logic [3:0]  AWADDR, WSTRB, ARADDR, ACTIVE_CHANNELS, RESULT_ADDR, trig, we_addr[$];
  logic [9:0]  CONV_RESULT;
  logic [15:0] RESULT_DATA, we_data[$];
  logic [31:0] WDATA, RDATA;
  int          fail_count, tests_run, cyc, start_count, irq_count, scan_count, n, m, we_time[$];
  logic [2:0]  src[5] = '{SRC_EXT_INT, SRC_TIMER, SRC_PWM, SRC_TOUCH, SRC_MANUAL};
  logic [15:0] fmt[4] = '{16'h015A, 16'hFF5A, 16'h5680, 16'hD680};

  assign {TOUCH_TRIGGER, PWM_INTERVAL, TIMER_MATCH, EXT_INT_EDGE} = trig;

  conv_seq_ctrl i_conv_seq_ctrl (.*);

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cyc++;
    if (CONVERT_START === 1'b1) start_count++;
    if (CONV_IRQ === 1'b1) irq_count++;
    if (SCAN_STEP === 1'b1) scan_count++;
    if (RESULT_WE === 1'b1) begin
      we_addr.push_back(RESULT_ADDR);
      we_data.push_back(RESULT_DATA);
      we_time.push_back(cyc);
    end
  end

  // ****************************************************
  // bus and check tasks
  // ****************************************************
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic write_reg(logic [3:0] addr, logic [15:0] data, logic [1:0] resp = RESP_OKAY);
    bit aw_left;
    bit w_left;
    @(posedge CLK);
    AWADDR  <= addr;
    WDATA   <= {16'h0000, data};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    aw_left = 1'b1;
    w_left  = 1'b1;
    // each channel is released at the edge it is taken
    while (aw_left || w_left) begin
      @(posedge CLK);
      if (AWREADY === 1'b1) aw_left = 1'b0;
      if (WREADY === 1'b1) w_left = 1'b0;
      AWVALID <= aw_left;
      WVALID  <= w_left;
    end
    do @(posedge CLK); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    check("write response", 32'(BRESP), 32'(resp));
  endtask

  task automatic read_reg(logic [3:0] addr, logic [15:0] want, string what, logic [1:0] resp = RESP_OKAY);
    @(posedge CLK);
    ARADDR  <= addr;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    check(what, RDATA, {16'h0000, want});
    check("read response", 32'(RRESP), 32'(resp));
  endtask

  task automatic pulse(logic [3:0] which);
    @(posedge CLK);
    trig <= which;
    @(posedge CLK);
    trig <= 4'h0;
  endtask

  task automatic wait_writes(int count);
    while (we_addr.size() < count) @(negedge CLK);
  endtask

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************
  // test sequence
  // ****************************************************
  initial begin
    RST_B       = 1'b0;
    AWADDR      = 4'h0;
    AWVALID     = 1'b0;
    WDATA       = 32'h0;
    WSTRB       = 4'hF;
    WVALID      = 1'b0;
    BREADY      = 1'b0;
    ARADDR      = 4'h0;
    ARVALID     = 1'b0;
    RREADY      = 1'b0;
    trig        = 4'h0;
    CONV_RESULT = 10'h15A;
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      read_reg(4'(4 * i), RESET_VALUE, "reset value");
    end
    write_reg(ADDR_CTRL_TWO, 16'hFFFF);
    write_reg(ADDR_CTRL_THREE, 16'hFFFF);
    write_reg(ADDR_CHAN_SEL, 16'hFFFF);
    write_reg(ADDR_CTRL_ONE, ~MASK_CTRL_ONE);
    read_reg(ADDR_CTRL_ONE, RESET_VALUE, "control one");
    read_reg(ADDR_CTRL_TWO, MASK_CTRL_TWO, "control two");
    write_reg(4'h2, 16'hFFFF, RESP_SLVERR);
    read_reg(4'h2, 16'h0000, "unmapped", RESP_SLVERR);
    read_reg(ADDR_CTRL_THREE, MASK_CTRL_THREE, "control three");
    read_reg(ADDR_CHAN_SEL, MASK_CHAN_SEL, "channel select");
    for (int s = 0; s < 2; s++) begin
      write_reg(ADDR_CHAN_SEL, s ? 16'h0101 : 16'h0000);
      repeat (4) @(negedge CLK);
      check("channel two input", 32'(POS_INPUT_2), 32'(1 + 3 * s));
      check("ground", 32'(NEG_TO_GROUND), 32'h1);
    end
    write_reg(ADDR_CTRL_THREE, 16'h0200);
    write_reg(ADDR_CTRL_TWO, 16'h0204);
    write_reg(ADDR_CTRL_ONE, 16'h00E2);
    pulse(4'hF);
    repeat (100) @(negedge CLK);
    check("start while disabled", start_count, 0);
    // enable first: a sample request in the enabling write is not honoured
    write_reg(ADDR_CTRL_ONE, 16'h80E0);
    for (int f = 0; f < 4; f++) begin
      n = start_count;
      write_reg(ADDR_CTRL_THREE, 16'h0200 | 16'(f));
      write_reg(ADDR_CTRL_ONE, 16'h80E2 | 16'(f << 8));
      while (start_count == n) @(negedge CLK);
      read_reg(ADDR_CTRL_ONE, 16'h80E0 | 16'(f << 8), "converting");
      wait_writes(4 * f + 4);
      repeat (4) @(negedge CLK);
      read_reg(ADDR_CTRL_ONE, 16'h80E1 | 16'(f << 8), "converted");
      for (int k = 0; k < 4; k++) begin
        check("buffer word", 32'(we_addr[4 * f + k]), 32'(4 * (f % 2) + k));
        check("result word", 32'(we_data[4 * f + k]), 32'(fmt[f]));
      end
      check("period", we_time[4 * f + 1] - we_time[4 * f], CONV_PERIODS * INSTR_CYCLES * (f + 1));
    end
    check("interrupts", irq_count, 2);
    write_reg(ADDR_CTRL_TWO, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      n = start_count;
      m = we_addr.size();
      write_reg(ADDR_CTRL_ONE, 16'h8002 | (16'(src[i]) << 5));
      pulse(~(4'h1 << i));
      repeat (20) @(negedge CLK);
      check("start on other trigger", start_count, n);
      check("sample hold", 32'(SAMPLE_HOLD), 32'h1);
      if (i == 4) write_reg(ADDR_CTRL_ONE, 16'h8000);
      else pulse(4'h1 << i);
      wait_writes(m + 1);
    end
    write_reg(ADDR_CTRL_TWO, 16'h0002);
    for (int s = 0; s < 3; s++) begin
      m = we_addr.size();
      write_reg(ADDR_CTRL_ONE, 16'h80E2);
      wait_writes(m + 1);
      repeat (4) @(negedge CLK);
      check("split word", 32'(we_addr[m]), 32'(8 * (s % 2)));
      read_reg(ADDR_CTRL_TWO, (s % 2) ? 16'h0002 : 16'h0082, "fill half");
    end
    write_reg(ADDR_CTRL_TWO, 16'h0404);
    n = start_count;
    write_reg(ADDR_CTRL_ONE, 16'h80E6);
    repeat (400) @(negedge CLK);
    check("automatic restart", 32'(start_count - n >= 2), 32'h1);
    check("scan step", 32'(scan_count > 0), 32'h1);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    complete_run();
  end
endmodule

// File: bench/conv_seq_ctrl_monitor.sv
`timescale 1ns/1ps
module conv_seq_ctrl_monitor
  import conv_seq_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
)(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [3:0]  AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [3:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        CONVERT_START,
  input wire logic [3:0]  ACTIVE_CHANNELS,
  input wire logic [2:0]  POS_INPUT_1,
  input wire logic [2:0]  POS_INPUT_2,
  input wire logic [2:0]  POS_INPUT_3,
  input wire logic [2:0]  POS_OPEN,
  input wire logic        NEG_TO_GROUND,
  input wire logic        CONV_IRQ
);
  // ****************************************************
  // shadow of written control fields
  // ****************************************************
  logic       enable_r;
  logic [1:0] count_r;
  logic [2:0] select_r;
  logic [2:0] quiet_r;
  logic [2:0] route_base;
  logic       route_open;
  wire        write_taken = AWVALID && AWREADY && WVALID && WREADY;

  assign route_base = select_r[0] ? 3'h3 : 3'h0;
  assign route_open = select_r[0] && SMALL_VARIANT;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      enable_r <= 1'b0;
      count_r  <= 2'h0;
      select_r <= 3'h0;
      quiet_r  <= 3'h0;
    end else begin
      if (write_taken && AWADDR == ADDR_CTRL_ONE) enable_r <= WDATA[POS_MODULE_ENABLE];
      if (write_taken && AWADDR == ADDR_CTRL_TWO) count_r <= WDATA[POS_CHAN_COUNT +: 2];
      if (write_taken && AWADDR == ADDR_CHAN_SEL) select_r <= WDATA[2:0];
      if (write_taken) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_write_taken;
    write_taken;
  endsequence
  sequence s_read_taken;
    ARVALID && ARREADY;
  endsequence
  sequence s_settled;
    quiet_r == 3'h7;
  endsequence

  a_write_answer: assert property (s_write_taken |=> BVALID)
    else $error("write not answered next cycle");
  a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  a_read_answer: assert property (s_read_taken |=> RVALID)
    else $error("read not answered next cycle");
  a_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  a_read_unmapped: assert property (s_read_taken ##0 ARADDR[1:0] != 2'h0 |=> RRESP == RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_enable_gate: assert property (!enable_r && !$past(enable_r) |-> !CONVERT_START)
    else $error("conversion started while disabled");
  a_start_single: assert property (CONVERT_START |=> !CONVERT_START [*8])
    else $error("conversion start repeated");
  a_irq_single: assert property (CONV_IRQ |=> !CONV_IRQ [*8])
    else $error("interrupt repeated");
  a_channel_mask: assert property (s_settled |-> ACTIVE_CHANNELS == (count_r[1] ? 4'hF : {2'h0, count_r[0], 1'b1}))
    else $error("channel mask wrong");
  a_route_inputs: assert property (s_settled |->
    POS_INPUT_1 == route_base && POS_OPEN == {route_open, route_open, 1'b0}
    && (route_open || POS_INPUT_2 == route_base + 3'h1 && POS_INPUT_3 == route_base + 3'h2))
    else $error("positive inputs wrong");
  a_neg_ground: assert property (s_settled ##0 !select_r[2] |-> NEG_TO_GROUND)
    else $error("negative inputs not grounded");
endmodule

bind conv_seq_ctrl conv_seq_ctrl_monitor #(.SMALL_VARIANT(SMALL_VARIANT)) i_conv_seq_ctrl_monitor (.*);

// File: rtl/conv_clock_gen.sv
`timescale 1ns/1ps
module conv_clock_gen
  import conv_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [7:0] clk_sel,
  output logic            tick
);

  // ****************************************************
  // instruction cycle prescale then period divider
  // ****************************************************
  logic [7:0] pre_r;
  logic [7:0] div_r;
  logic [7:0] sel_lim;
  wire        pre_end = (pre_r == INSTR_CYCLES - 8'h01);
  wire        div_end = (div_r >= sel_lim);

  // reserved selections clamp to the longest legal period
  assign sel_lim = (clk_sel > CLK_SEL_MAX) ? CLK_SEL_MAX : clk_sel;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= 8'h00;
      div_r <= 8'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      pre_r <= 8'h00;
      div_r <= 8'h00;
      tick  <= 1'b0;
    end else begin
      pre_r <= pre_end ? 8'h00 : pre_r + 8'h01;
      tick  <= pre_end && div_end;
      if (pre_end) begin
        div_r <= div_end ? 8'h00 : div_r + 8'h01;
      end
    end
  end

endmodule

// File: rtl/conv_seq_ctrl.sv
`timescale 1ns/1ps
// Operation
// - source field picks manual, external_interrupt_zero edge, timer, pwm, touch or internal counter trigger
// - non-manual trigger clears sample bit itself; manual clear starts conversion
// - done flag set when a conversion cycle completes
// - done flag cleared at start of each conversion
// - software may only clear done; clear never disturbs running conversion
// - scan enable steps channel-0 sample-a input through scan list
// - channel count picks channel 0, channels 0-1, or channels 0-3
// - interrupt after every (field+1)-th completed sequence
// - fill status shows half being filled in split mode only
// - auto-sample time is 0 to 31 conversion-clock periods
// - conversion clock period is instruction cycle times (select+1), max 64
// - sample-b negative 0x connects channels 1-3 negative to analog ground
// - larger parts with positive-b set route inputs 3,4,5
// - positive-b clear routes inputs 0,1,2 to channels 1-3
// - smallest part with positive-b set: channel 1 input 3, others open
// - while scanning, interrupt count also restarts the scan list
// - results go sequentially into sixteen buffer words
module conv_seq_ctrl
  import conv_seq_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
)(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        EXT_INT_EDGE,
  input  wire logic        TIMER_MATCH,
  input  wire logic        PWM_INTERVAL,
  input  wire logic        TOUCH_TRIGGER,
  input  wire logic [9:0]  CONV_RESULT,
  output logic             SAMPLE_HOLD,
  output logic             CONVERT_START,
  output logic [3:0]       ACTIVE_CHANNELS,
  output logic             SCAN_STEP,
  output logic [2:0]       POS_INPUT_1,
  output logic [2:0]       POS_INPUT_2,
  output logic [2:0]       POS_INPUT_3,
  output logic [2:0]       POS_OPEN,
  output logic             NEG_TO_GROUND,
  output logic             RESULT_WE,
  output logic [3:0]       RESULT_ADDR,
  output logic [15:0]      RESULT_DATA,
  output logic             CONV_IRQ
);

  // ****************************************************
  // registers and state
  // ****************************************************
  logic [15:0] ctrl_one_r;
  logic [15:0] ctrl_two_r;
  logic [15:0] ctrl_three_r;
  logic [15:0] chan_sel_r;
  logic        sample_r;
  logic        done_r;
  logic        fill_half_r;
  logic [3:0]  seq_cnt_r;
  logic [3:0]  buf_ptr_r;
  logic [4:0]  tcnt_r;
  logic [1:0]  ch_idx_r;
  seq_state_t  state_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [3:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        tick;

  // ****************************************************
  // field decode
  // ****************************************************
  wire       module_enable      = ctrl_one_r[POS_MODULE_ENABLE];
  wire [1:0] output_format      = ctrl_one_r[POS_FORMAT +: 2];
  wire [2:0] sample_clock_source = ctrl_one_r[POS_SRC +: 3];
  wire       auto_sample_enable = ctrl_one_r[POS_AUTO_SAMPLE];
  wire       scan_enable        = ctrl_two_r[POS_SCAN_ENABLE];
  wire [1:0] channel_count      = ctrl_two_r[POS_CHAN_COUNT +: 2];
  wire [3:0] seq_per_int        = ctrl_two_r[POS_SEQ_PER_INT +: 4];
  wire       buffer_fill_mode   = ctrl_two_r[POS_FILL_MODE];
  wire [4:0] auto_sample_time   = ctrl_three_r[POS_SAMPLE_TIME +: 5];
  wire [7:0] clk_select         = ctrl_three_r[7:0];

  wire [1:0] last_ch = channel_count[1] ? 2'h3 : {1'b0, channel_count[0]};
  wire [3:0] ch_mask = channel_count[1] ? 4'hF : (channel_count[0] ? 4'h3 : 4'h1);

  wire trig_hit = (sample_clock_source == SRC_EXT_INT)  ? EXT_INT_EDGE :
                  (sample_clock_source == SRC_TIMER)    ? TIMER_MATCH :
                  (sample_clock_source == SRC_PWM)      ? PWM_INTERVAL :
                  (sample_clock_source == SRC_TOUCH)    ? TOUCH_TRIGGER :
                  (sample_clock_source == SRC_INTERNAL) ? (tick && tcnt_r >= auto_sample_time) :
                  1'b0;

  // ****************************************************
  // bus decode
  // ****************************************************
  wire        aw_ok   = aw_hold_r || AWVALID;
  wire        w_ok    = w_hold_r || WVALID;
  wire [3:0]  wa      = aw_hold_r ? aw_addr_r : AWADDR;
  wire [31:0] wd      = w_hold_r ? w_data_r : WDATA;
  wire [3:0]  ws      = w_hold_r ? w_strb_r : WSTRB;
  wire        wr_go   = aw_ok && w_ok && !BVALID;
  wire [15:0] wmask   = {{8{ws[1]}}, {8{ws[0]}}};
  wire        wr_one  = wr_go && wa == ADDR_CTRL_ONE;
  wire        wr_two  = wr_go && wa == ADDR_CTRL_TWO;
  wire        wr_thr  = wr_go && wa == ADDR_CTRL_THREE;
  wire        wr_chs  = wr_go && wa == ADDR_CHAN_SEL;
  wire        wr_hit  = wr_one || wr_two || wr_thr || wr_chs;
  wire        rd_go   = ARVALID && !RVALID;
  wire        sw_samp = wr_one && ws[0] && wd[POS_SAMPLE];
  wire        sw_stop = wr_one && ws[0] && !wd[POS_SAMPLE];
  wire        sw_done_clr = wr_one && ws[0] && !wd[POS_DONE];

  wire [15:0] rd_one = {ctrl_one_r[15:2], sample_r, done_r};
  wire [15:0] rd_two = {ctrl_two_r[15:8], fill_half_r && buffer_fill_mode, ctrl_two_r[6:0]};
  wire [15:0] rd_val = (ARADDR == ADDR_CTRL_ONE)   ? rd_one :
                       (ARADDR == ADDR_CTRL_TWO)   ? rd_two :
                       (ARADDR == ADDR_CTRL_THREE) ? ctrl_three_r :
                       (ARADDR == ADDR_CHAN_SEL)   ? chan_sel_r : 16'h0000;
  wire        rd_hit = ARADDR == ADDR_CTRL_ONE || ARADDR == ADDR_CTRL_TWO ||
                       ARADDR == ADDR_CTRL_THREE || ARADDR == ADDR_CHAN_SEL;

  // ****************************************************
  // sequencer decode
  // ****************************************************
  wire in_sample   = state_r == ST_SAMPLE;
  wire in_conv     = state_r == ST_CONV;
  wire conv_begin  = in_sample && (sample_clock_source == SRC_MANUAL ? sw_stop : trig_hit);
  wire ch_done     = in_conv && tick && tcnt_r == 5'(CONV_PERIODS - 1);
  wire seq_done    = ch_done && ch_idx_r == last_ch;
  wire irq_now     = seq_done && seq_cnt_r == seq_per_int;
  wire [3:0] half_base = (buffer_fill_mode && fill_half_r) ? 4'h8 : 4'h0;

  logic [15:0] fmt_word;
  wire  [9:0]  res = CONV_RESULT;
  always_comb begin
    case (output_format)
      2'h0:    fmt_word = {6'h00, res};
      2'h1:    fmt_word = {{6{~res[9]}}, ~res[9], res[8:0]};
      2'h2:    fmt_word = {res, 6'h00};
      default: fmt_word = {~res[9], res[8:0], 6'h00};
    endcase
  end

  wire [2:0] pos_base = chan_sel_r[POS_POS_B] ? 3'h3 : 3'h0;
  wire [2:0] pos_base_a = chan_sel_r[POS_POS_A] ? 3'h3 : 3'h0;

  conv_clock_gen u_clk (
    .clk     (CLK),
    .rst_b   (RST_B),
    .run     (module_enable),
    .clk_sel (clk_select),
    .tick    (tick)
  );

  // ****************************************************
  // register bus
  // ****************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
      RVALID    <= 1'b0;
      RDATA     <= 32'h0000_0000;
      RRESP     <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_hold_r <= 1'b1;
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
      if (rd_go) begin
        RVALID <= 1'b1;
        RDATA  <= {16'h0000, rd_val};
        RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  assign AWREADY = !aw_hold_r && !BVALID;
  assign WREADY  = !w_hold_r && !BVALID;
  assign ARREADY = !RVALID;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_one_r   <= RESET_VALUE;
      ctrl_two_r   <= RESET_VALUE;
      ctrl_three_r <= RESET_VALUE;
      chan_sel_r   <= RESET_VALUE;
    end else begin
      if (wr_one) ctrl_one_r <= (ctrl_one_r & ~(wmask & MASK_CTRL_ONE)) | (wd[15:0] & wmask & MASK_CTRL_ONE);
      if (wr_two) ctrl_two_r <= (ctrl_two_r & ~(wmask & MASK_CTRL_TWO)) | (wd[15:0] & wmask & MASK_CTRL_TWO);
      if (wr_thr) ctrl_three_r <= (ctrl_three_r & ~(wmask & MASK_CTRL_THREE)) | (wd[15:0] & wmask & MASK_CTRL_THREE);
      if (wr_chs) chan_sel_r <= (chan_sel_r & ~(wmask & MASK_CHAN_SEL)) | (wd[15:0] & wmask & MASK_CHAN_SEL);
    end
  end

  // ****************************************************
  // sample / convert sequencer
  // ****************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r     <= ST_IDLE;
      sample_r    <= 1'b0;
      done_r      <= 1'b0;
      tcnt_r      <= 5'h00;
      ch_idx_r    <= 2'h0;
      seq_cnt_r   <= 4'h0;
      buf_ptr_r   <= 4'h0;
      fill_half_r <= 1'b0;
    end else if (!module_enable) begin
      state_r  <= ST_IDLE;
      sample_r <= 1'b0;
      tcnt_r   <= 5'h00;
      if (sw_done_clr) done_r <= 1'b0;
    end else begin
      if (seq_done) done_r <= 1'b1;
      else if (conv_begin) done_r <= 1'b0;
      else if (sw_done_clr) done_r <= 1'b0;
      if (tick && tcnt_r != 5'h1F) tcnt_r <= tcnt_r + 5'h01;
      case (state_r)
        ST_IDLE: begin
          if (sw_samp || auto_sample_enable) begin
            state_r  <= ST_SAMPLE;
            sample_r <= 1'b1;
            tcnt_r   <= 5'h00;
          end
        end
        ST_SAMPLE: begin
          if (conv_begin) begin
            state_r  <= ST_CONV;
            sample_r <= 1'b0;
            tcnt_r   <= 5'h00;
            ch_idx_r <= 2'h0;
          end
        end
        ST_CONV: begin
          if (ch_done) begin
            tcnt_r    <= 5'h00;
            buf_ptr_r <= (irq_now || buf_ptr_r == 4'(RESULT_WORDS - 1)) ? half_base : buf_ptr_r + 4'h1;
            if (irq_now) begin
              fill_half_r <= buffer_fill_mode ? ~fill_half_r : 1'b0;
              buf_ptr_r   <= (buffer_fill_mode && !fill_half_r) ? 4'h8 : 4'h0;
            end
            if (seq_done) begin
              ch_idx_r  <= 2'h0;
              seq_cnt_r <= irq_now ? 4'h0 : seq_cnt_r + 4'h1;
              state_r   <= auto_sample_enable ? ST_SAMPLE : ST_IDLE;
              sample_r  <= auto_sample_enable;
            end else begin
              ch_idx_r <= ch_idx_r + 2'h1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // outputs to analog core and buffer
  // ****************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SAMPLE_HOLD     <= 1'b0;
      CONVERT_START   <= 1'b0;
      ACTIVE_CHANNELS <= 4'h1;
      SCAN_STEP       <= 1'b0;
      POS_INPUT_1     <= 3'h0;
      POS_INPUT_2     <= 3'h1;
      POS_INPUT_3     <= 3'h2;
      POS_OPEN        <= 3'h0;
      NEG_TO_GROUND   <= 1'b1;
      RESULT_WE       <= 1'b0;
      RESULT_ADDR     <= 4'h0;
      RESULT_DATA     <= 16'h0000;
      CONV_IRQ        <= 1'b0;
    end else begin
      SAMPLE_HOLD     <= sample_r;
      CONVERT_START   <= conv_begin;
      ACTIVE_CHANNELS <= ch_mask;
      // scan advances per sequence, restarts on interrupt boundary
      SCAN_STEP       <= scan_enable && seq_done && !irq_now;
      POS_INPUT_1     <= in_sample ? pos_base_a : pos_base;
      POS_INPUT_2     <= (in_sample ? pos_base_a : pos_base) + 3'h1;
      POS_INPUT_3     <= (in_sample ? pos_base_a : pos_base) + 3'h2;
      POS_OPEN        <= (SMALL_VARIANT && (in_sample ? chan_sel_r[POS_POS_A] : chan_sel_r[POS_POS_B]))
                         ? 3'b110 : 3'b000;
      NEG_TO_GROUND   <= in_sample ? !chan_sel_r[POS_NEG_A + 1] : !chan_sel_r[POS_NEG_B + 1];
      RESULT_WE       <= ch_done;
      RESULT_ADDR     <= buf_ptr_r;
      RESULT_DATA     <= fmt_word;
      CONV_IRQ        <= irq_now;
    end
  end

endmodule

// File: rtl/conv_seq_pkg.sv
package conv_seq_pkg;

  // ****************************************************
  // register byte addresses
  // ****************************************************
  localparam logic [3:0] ADDR_CTRL_ONE   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO   = 4'h4;
  localparam logic [3:0] ADDR_CTRL_THREE = 4'h8;
  localparam logic [3:0] ADDR_CHAN_SEL   = 4'hC;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int POS_MODULE_ENABLE = 15;
  localparam int POS_FORMAT        = 8;
  localparam int POS_SRC           = 5;
  localparam int POS_AUTO_SAMPLE   = 2;
  localparam int POS_SAMPLE        = 1;
  localparam int POS_DONE          = 0;
  localparam int POS_SCAN_ENABLE   = 10;
  localparam int POS_CHAN_COUNT    = 8;
  localparam int POS_FILL_STATUS   = 7;
  localparam int POS_SEQ_PER_INT   = 2;
  localparam int POS_FILL_MODE     = 1;
  localparam int POS_CLK_SOURCE    = 15;
  localparam int POS_SAMPLE_TIME   = 8;
  localparam int POS_NEG_B         = 9;
  localparam int POS_POS_B         = 8;
  localparam int POS_NEG_A         = 1;
  localparam int POS_POS_A         = 0;

  // ****************************************************
  // writable masks and reset values
  // ****************************************************
  localparam logic [15:0] MASK_CTRL_ONE   = 16'h83E6;
  localparam logic [15:0] MASK_CTRL_TWO   = 16'h073E;
  localparam logic [15:0] MASK_CTRL_THREE = 16'h9FFF;
  localparam logic [15:0] MASK_CHAN_SEL   = 16'h0707;
  localparam logic [15:0] RESET_VALUE     = 16'h0000;

  // ****************************************************
  // trigger source codes
  // ****************************************************
  localparam logic [2:0] SRC_MANUAL   = 3'h0;
  localparam logic [2:0] SRC_EXT_INT  = 3'h1;
  localparam logic [2:0] SRC_TIMER    = 3'h2;
  localparam logic [2:0] SRC_PWM      = 3'h3;
  localparam logic [2:0] SRC_TOUCH    = 3'h6;
  localparam logic [2:0] SRC_INTERNAL = 3'h7;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int          CLK_MHZ          = 200;
  localparam int          INSTR_CYCLE_NS   = 10;
  localparam int          INSTR_CYCLES_RAW = (INSTR_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  INSTR_CYCLES     = 8'(INSTR_CYCLES_RAW);
  localparam logic [7:0]  CLK_SEL_MAX      = 8'h3F;
  localparam int          CONV_PERIODS     = 12;
  localparam int          RESULT_WORDS     = 16;
  localparam int          RESULT_BITS      = 10;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } seq_state_t;

endpackage
